// [hci_uart_pkg.sv]
// constants, register map and field layout of the host-link serial port
// assumes a 200 MHz system clock and a classic wishbone register bus
package hci_uart_pkg;
   localparam int CLK_HZ = 200000000;
   localparam int DEFAULT_BAUD = 115200;
   localparam logic [15:0] DIV_RST = 16'(CLK_HZ / DEFAULT_BAUD);
   localparam int DATA_BITS = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int PTR_W = 4;
   localparam int CNT_W = 5;
   // register word offsets (byte addresses)
   localparam logic [3:0] ADDR_DATA = 4'h0;
   localparam logic [3:0] ADDR_CTRL = 4'h4;
   localparam logic [3:0] ADDR_DIV = 4'h8;
   localparam logic [3:0] ADDR_STAT = 4'hC;
   // control fields
   localparam int CTRL_RTS_EN = 0;
   localparam int CTRL_RTS_POL = 1;
   localparam int CTRL_CTS_EN = 2;
   localparam int CTRL_CTS_POL = 3;
   localparam int CTRL_LVL_LSB = 8;
   localparam int CTRL_LVL_W = 5;
   localparam logic [CTRL_LVL_W-1:0] RTS_LVL_RST = 5'h04;
   // reset value: both handshakes enabled, active low, threshold four
   localparam logic [12:0] CTRL_RST = {RTS_LVL_RST, 8'h05};
   // status fields
   localparam int STAT_RX_EMPTY = 0;
   localparam int STAT_TX_FULL = 1;
   localparam int STAT_RTS = 2;
   localparam int STAT_CTS = 3;
   localparam int STAT_TX_BUSY = 4;
   localparam int STAT_FRAME_ERR = 5;
   localparam int STAT_RX_OVF = 6;
   localparam int STAT_RX_CNT_LSB = 8;
   localparam int STAT_TX_CNT_LSB = 16;
endpackage

// [hci_uart.sv]
// host-link serial port with request/clear-to-send flow control
// assumes pins synchronous to clk; one clock, wishbone classic slave
// Behaviour
// - full duplex, 8 data bits, one stop bit, no parity each way
// - bit rate set by a divider register; both ends must agree
// - rts output enable bit, on by default; off leaves rts inactive
// - rts active while rx fifo count below threshold, else inactive
// - rts threshold is configurable, default four entries
// - rts polarity selectable, active low by default
// - cts input enable bit, on by default; off ignores cts
// - transmitter samples cts before taking each character from tx fifo
// - inactive cts holds transmission; resumes with remaining data
// - cts polarity selectable, active low by default
//
// Our own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
module hci_uart
   import hci_uart_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic wb_ack_o,
   output logic wb_err_o,
   input wire logic rxd,
   output logic txd,
   input wire logic cts,
   output logic rts
);
   typedef enum logic [2:0] {
      TX_IDLE = 3'b001,
      TX_SHIFT = 3'b010,
      TX_STOP = 3'b100
   } tx_state_type;

   typedef enum logic [3:0] {
      RX_IDLE = 4'b0001,
      RX_START = 4'b0010,
      RX_SHIFT = 4'b0100,
      RX_STOP = 4'b1000
   } rx_state_type;

   typedef struct packed {
      logic [31:0] dat;
      logic ack;
      logic err;
      logic [12:0] ctrl;
      logic [15:0] div;
      logic [FIFO_DEPTH-1:0][7:0] txq;
      logic [PTR_W-1:0] txw;
      logic [PTR_W-1:0] txr;
      logic [CNT_W-1:0] txc;
      logic [FIFO_DEPTH-1:0][7:0] rxq;
      logic [PTR_W-1:0] rxw;
      logic [PTR_W-1:0] rxr;
      logic [CNT_W-1:0] rxc;
      tx_state_type ts;
      logic [15:0] tdiv;
      logic [2:0] tbit;
      logic [7:0] tsh;
      logic txd;
      rx_state_type rs;
      logic [15:0] rdiv;
      logic [2:0] rbit;
      logic [7:0] rsh;
      logic rx_prev;
      logic ferr;
      logic ovf;
      logic rts;
   } state_type;

   state_type s_r;
   state_type s_nxt;

   // input level with polarity applied
   function automatic logic active_level(input logic pin, input logic pol_high);
      active_level = pol_high ? pin : ~pin;
   endfunction

   // reload value for a full bit time, divider of zero treated as one
   function automatic logic [15:0] bit_time(input logic [15:0] d);
      bit_time = (d == 16'h0000) ? 16'h0000 : d - 16'h0001;
   endfunction

   // half a bit time, to land the first sample mid start bit
   function automatic logic [15:0] half_time(input logic [15:0] d);
      half_time = {1'b0, d[15:1]};
   endfunction

   // divider count one step closer to the sample edge
   function automatic logic [15:0] tick_down(input logic [15:0] d);
      tick_down = d - 16'h0001;
   endfunction

   // fill count at the fifo's capacity
   function automatic logic at_capacity(input logic [CNT_W-1:0] c);
      at_capacity = (c == CNT_W'(FIFO_DEPTH));
   endfunction

   logic bus_req;
   logic cts_ok;
   logic tx_full;
   logic rx_empty;
   logic tx_pop;
   logic rx_push;
   logic rx_pop;
   logic tx_push;
   logic rx_tick;
   logic [31:0] stat_word;

   always_comb begin
      s_nxt = s_r;
      bus_req = wb_cyc_i && wb_stb_i && !s_r.ack && !s_r.err;
      tx_full = at_capacity(s_r.txc);
      rx_empty = (s_r.rxc == '0);
      // one-cycle sample enable from the receive bit divider
      rx_tick = (s_r.rdiv == '0);
      // cts gate is bypassed when its enable bit is clear
      cts_ok = !s_r.ctrl[CTRL_CTS_EN] ||
         active_level(cts, s_r.ctrl[CTRL_CTS_POL]);
      tx_pop = 1'b0;
      rx_push = 1'b0;
      rx_pop = 1'b0;
      tx_push = 1'b0;
      stat_word = '0;
      stat_word[STAT_RX_EMPTY] = rx_empty;
      stat_word[STAT_TX_FULL] = tx_full;
      stat_word[STAT_RTS] = s_r.rts;
      stat_word[STAT_CTS] = cts_ok;
      stat_word[STAT_TX_BUSY] = (s_r.ts != TX_IDLE);
      stat_word[STAT_FRAME_ERR] = s_r.ferr;
      stat_word[STAT_RX_OVF] = s_r.ovf;
      stat_word[STAT_RX_CNT_LSB +: CNT_W] = s_r.rxc;
      stat_word[STAT_TX_CNT_LSB +: CNT_W] = s_r.txc;

      // wishbone slave: one wait state, ack for one cycle
      s_nxt.ack = 1'b0;
      s_nxt.err = 1'b0;
      if (bus_req) begin
         s_nxt.dat = '0;
         unique case (wb_adr_i)
            ADDR_DATA: begin
               if (wb_we_i) begin
                  tx_push = wb_sel_i[0] && !tx_full;
               end else begin
                  // an empty fifo reads as zero and is not popped
                  if (!rx_empty) begin
                     s_nxt.dat[7:0] = s_r.rxq[s_r.rxr];
                     rx_pop = 1'b1;
                  end
               end
               s_nxt.ack = 1'b1;
            end
            ADDR_CTRL: begin
               if (wb_we_i) begin
                  if (wb_sel_i[0]) begin
                     s_nxt.ctrl[7:0] = wb_dat_i[7:0];
                  end
                  if (wb_sel_i[1]) begin
                     s_nxt.ctrl[12:8] = wb_dat_i[12:8];
                  end
               end
               s_nxt.dat[12:0] = s_r.ctrl;
               s_nxt.ack = 1'b1;
            end
            ADDR_DIV: begin
               if (wb_we_i) begin
                  if (wb_sel_i[0]) begin
                     s_nxt.div[7:0] = wb_dat_i[7:0];
                  end
                  if (wb_sel_i[1]) begin
                     s_nxt.div[15:8] = wb_dat_i[15:8];
                  end
               end
               s_nxt.dat[15:0] = s_r.div;
               s_nxt.ack = 1'b1;
            end
            ADDR_STAT: begin
               // sticky error flags clear on status write of ones
               if (wb_we_i && wb_sel_i[0]) begin
                  if (wb_dat_i[STAT_FRAME_ERR]) begin
                     s_nxt.ferr = 1'b0;
                  end
                  if (wb_dat_i[STAT_RX_OVF]) begin
                     s_nxt.ovf = 1'b0;
                  end
               end
               s_nxt.dat = stat_word;
               s_nxt.ack = 1'b1;
            end
            default: begin
               s_nxt.err = 1'b1;
            end
         endcase
      end

      // transmitter
      unique case (s_r.ts)
         TX_IDLE: begin
            s_nxt.txd = 1'b1;
            // cts looked at before each character leaves the fifo
            if (s_r.txc != '0 && cts_ok) begin
               tx_pop = 1'b1;
               s_nxt.tsh = s_r.txq[s_r.txr];
               s_nxt.txd = 1'b0;
               s_nxt.tdiv = bit_time(s_r.div);
               s_nxt.tbit = '0;
               s_nxt.ts = TX_SHIFT;
            end
         end
         TX_SHIFT: begin
            if (s_r.tdiv == '0) begin
               s_nxt.tdiv = bit_time(s_r.div);
               s_nxt.txd = s_r.tsh[0];
               s_nxt.tsh = {1'b0, s_r.tsh[7:1]};
               s_nxt.tbit = s_r.tbit + 3'h1;
               if (s_r.tbit == 3'(DATA_BITS - 1)) begin
                  s_nxt.ts = TX_STOP;
               end
            end else begin
               s_nxt.tdiv = s_r.tdiv - 16'h0001;
            end
         end
         TX_STOP: begin
            if (s_r.tdiv == '0) begin
               s_nxt.tdiv = bit_time(s_r.div);
               s_nxt.txd = 1'b1;
               s_nxt.ts = TX_IDLE;
            end else begin
               s_nxt.tdiv = s_r.tdiv - 16'h0001;
            end
         end
      endcase
      // stop bit lasts one bit time before idle allows the next start
      if (s_r.ts == TX_IDLE && s_r.tdiv != '0) begin
         s_nxt.tdiv = s_r.tdiv - 16'h0001;
         tx_pop = 1'b0;
         s_nxt.ts = TX_IDLE;
         s_nxt.txd = 1'b1;
      end

      // receiver: samples at mid bit
      s_nxt.rx_prev = rxd;
      unique case (s_r.rs)
         RX_IDLE: begin
            // rx_prev resets high, so no false start follows reset
            if (s_r.rx_prev && !rxd) begin
               s_nxt.rdiv = half_time(s_r.div);
               s_nxt.rbit = '0;
               s_nxt.rs = RX_START;
            end
         end
         RX_START: begin
            if (rx_tick) begin
               s_nxt.rdiv = bit_time(s_r.div);
               // a low pulse shorter than half a bit is not a start bit
               s_nxt.rs = rxd ? RX_IDLE : RX_SHIFT;
            end else begin
               s_nxt.rdiv = tick_down(s_r.rdiv);
            end
         end
         RX_SHIFT: begin
            if (rx_tick) begin
               s_nxt.rdiv = bit_time(s_r.div);
               s_nxt.rsh = {rxd, s_r.rsh[7:1]};
               s_nxt.rbit = s_r.rbit + 3'h1;
               if (s_r.rbit == 3'(DATA_BITS - 1)) begin
                  s_nxt.rs = RX_STOP;
               end
            end else begin
               s_nxt.rdiv = tick_down(s_r.rdiv);
            end
         end
         RX_STOP: begin
            if (rx_tick) begin
               s_nxt.rs = RX_IDLE;
               if (!rxd) begin
                  s_nxt.ferr = 1'b1;
               end else if (at_capacity(s_r.rxc)) begin
                  // a full fifo drops the character and flags overflow
                  s_nxt.ovf = 1'b1;
               end else begin
                  rx_push = 1'b1;
               end
            end else begin
               s_nxt.rdiv = tick_down(s_r.rdiv);
            end
         end
      endcase

      // fifo bookkeeping; set of error flags wins over a clear above
      if (tx_push) begin
         s_nxt.txq[s_r.txw] = wb_dat_i[7:0];
         s_nxt.txw = s_r.txw + PTR_W'(1);
      end
      if (tx_pop) begin
         s_nxt.txr = s_r.txr + PTR_W'(1);
      end
      s_nxt.txc = s_r.txc + CNT_W'(tx_push) - CNT_W'(tx_pop);
      if (rx_push) begin
         s_nxt.rxq[s_r.rxw] = s_r.rsh;
         s_nxt.rxw = s_r.rxw + PTR_W'(1);
      end
      if (rx_pop) begin
         s_nxt.rxr = s_r.rxr + PTR_W'(1);
      end
      s_nxt.rxc = s_r.rxc + CNT_W'(rx_push) - CNT_W'(rx_pop);

      // request-to-send from next fill level, so it never lags a push
      if (!s_nxt.ctrl[CTRL_RTS_EN]) begin
         s_nxt.rts = ~s_nxt.ctrl[CTRL_RTS_POL];
      end else begin
         s_nxt.rts = (s_nxt.rxc < s_nxt.ctrl[CTRL_LVL_LSB +: CTRL_LVL_W]) ~^
            s_nxt.ctrl[CTRL_RTS_POL];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r <= '0;
         s_r.ctrl <= CTRL_RST;
         s_r.div <= DIV_RST;
         s_r.ts <= TX_IDLE;
         s_r.rs <= RX_IDLE;
         s_r.txd <= 1'b1;
         s_r.rx_prev <= 1'b1;
         s_r.rts <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign wb_dat_o = s_r.dat;
   assign wb_ack_o = s_r.ack;
   assign wb_err_o = s_r.err;
   assign txd = s_r.txd;
   assign rts = s_r.rts;
endmodule

// [hci_uart_checker_assertions.sv]
// checker for the host-link serial port, bound to hci_uart
// assumes ctrl and div change only through acked wishbone writes
`timescale 1ns/1ps
module hci_uart_checker
   import hci_uart_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   input wire logic rxd,
   input wire logic txd,
   input wire logic cts,
   input wire logic rts
);
   logic [12:0] ctrl_t;
   logic [15:0] div_t;
   logic [15:0] sub;
   logic [3:0] bi;
   logic fr, txd_q, start, cts_ok, wr, req;
   assign wr = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i;
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   assign start = !fr && txd_q && !txd;
   assign cts_ok = !ctrl_t[CTRL_CTS_EN] || (cts == ctrl_t[CTRL_CTS_POL]);
   // frame tracker; div must not change mid-frame
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_t <= CTRL_RST;
         div_t <= DIV_RST;
         fr <= 1'b0;
         sub <= 16'h0000;
         bi <= 4'h0;
         txd_q <= 1'b1;
      end else begin
         txd_q <= txd;
         if (wr && wb_adr_i == ADDR_CTRL && wb_sel_i[0]) ctrl_t[7:0] <= wb_dat_i[7:0];
         if (wr && wb_adr_i == ADDR_CTRL && wb_sel_i[1]) ctrl_t[12:8] <= wb_dat_i[12:8];
         if (wr && wb_adr_i == ADDR_DIV) div_t <= wb_dat_i[15:0];
         if (start) begin
            fr <= 1'b1;
            sub <= 16'h0001;
            bi <= 4'h0;
         end else if (fr && sub == div_t - 16'h0001) begin
            sub <= 16'h0000;
            bi <= bi + 4'h1;
            fr <= (bi != 4'h9);
         end else if (fr) begin
            sub <= sub + 16'h0001;
         end
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   start_low_a: assert property (fr && bi == 4'h0 |-> !txd)
      else $error("start bit not low");
   stop_high_a: assert property (fr && bi == 4'h9 |-> txd)
      else $error("stop bit not high");
   bit_hold_a: assert property (fr && sub != 16'h0000 |-> $stable(txd))
      else $error("txd changed inside a bit time");
   cts_gate_a: assert property (start |-> $past(cts_ok) || $past(cts_ok, 2))
      else $error("character started without clear-to-send");
   rts_off_a: assert property (!ctrl_t[CTRL_RTS_EN] && $stable(ctrl_t)
      && $past(ctrl_t, 2) == ctrl_t |-> rts == !ctrl_t[CTRL_RTS_POL])
      else $error("disabled rts not inactive");
   bus_answer_a: assert property (req |=> wb_ack_o ^ wb_err_o)
      else $error("no single answer one cycle after request");
   answer_pulse_a: assert property (wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o)
      else $error("answer longer than one cycle");
   unmapped_err_a: assert property (req && wb_adr_i[1:0] != 2'h0 |=> wb_err_o)
      else $error("unmapped address not refused");
endmodule
bind hci_uart hci_uart_checker chk (.clk(clk), .rst(rst), .wb_adr_i(wb_adr_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
   .rxd(rxd), .txd(txd), .cts(cts), .rts(rts));

// [hci_host_model.sv]
// host side of the serial link: sends, receives, drives clear-to-send
// assumes one polarity for both handshakes and a fixed bit time
`timescale 1ns/1ps
module hci_host_model (
   input wire logic clk,
   input wire logic dev_txd,
   input wire logic dev_rts,
   input wire logic [15:0] div,
   input wire logic pol,
   input wire logic ready,
   output logic host_txd,
   output logic cts
);
   logic [7:0] got_q[$];
   initial host_txd = 1'b1;
   assign cts = pol ? ready : !ready;
   task automatic send_char(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      while (dev_rts !== pol) @(posedge clk);
      for (int i = 0; i < 10; i++) begin
         host_txd <= f[i];
         repeat (div) @(posedge clk);
      end
   endtask
   // mid-bit sampling; a bad stop bit drops the character
   always begin
      logic [7:0] b;
      @(negedge dev_txd);
      repeat (div / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         repeat (div) @(posedge clk);
         b[i] = dev_txd;
      end
      repeat (div) @(posedge clk);
      if (dev_txd === 1'b1) got_q.push_back(b);
   end
endmodule

// [test_hci_uart.sv]
// self-checking bench for the host-link serial port
// assumes the host model and checker files are compiled first
`timescale 1ns/1ps
module test_hci_uart import hci_uart_pkg::*;;
   localparam logic [15:0] SIM_DIV = 16'h0008;
   logic clk, rst, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, wb_err_o, rxd, txd, cts, rts;
   logic [3:0] wb_adr_i, wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic e, pol, ready;
   logic [7:0] exp_q[$];
   int n_errors = 0;
   int cmp_count = 0;
   hci_uart dut (.clk(clk), .rst(rst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .rxd(rxd),
      .txd(txd), .cts(cts), .rts(rts));
   hci_host_model host (.clk(clk), .dev_txd(txd), .dev_rts(rts), .div(SIM_DIV),
      .pol(pol), .ready(ready), .host_txd(rxd), .cts(cts));
   task automatic check(input logic [31:0] seen, input logic [31:0] expv);
      cmp_count++;
      if (seen !== expv) begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, expv);
      end
   endtask
   // expected request-to-send pin for a fill count and a configuration
   function automatic logic exp_rts(input int cnt, input int lvl, input logic hi,
         input logic en);
      return (en && cnt < lvl) ? hi : !hi;
   endfunction
   task automatic give_verdict();
      $display("compares %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // waits for ack or err; a dead slave is ended by the watchdog
   task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
      wb_adr_i <= a;
      wb_we_i <= w;
      wb_dat_i <= d;
      wb_sel_i <= 4'hF;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      do begin
         @(posedge clk);
      end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
      q = wb_dat_o;
      e = wb_err_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk);
   endtask
   task automatic tx_burst(input int n);
      for (int i = 0; i < n; i++) begin
         exp_q.push_back(8'($urandom));
         wb(ADDR_DATA, 1'b1, {24'h000000, exp_q[exp_q.size() - 1]});
      end
   endtask
   task automatic tx_check();
      for (int i = 0; i < 3000 && host.got_q.size() < exp_q.size(); i++) @(posedge clk);
      check(32'(host.got_q.size()), 32'(exp_q.size()));
      while (exp_q.size() > 0 && host.got_q.size() > 0)
         check(32'(host.got_q.pop_front()), 32'(exp_q.pop_front()));
      exp_q.delete();
      host.got_q.delete();
   endtask
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      #300000;
      n_errors++;
      give_verdict();
   end
   initial begin
      {rst, wb_we_i, wb_cyc_i, wb_stb_i, pol, ready} = 6'h21;
      {wb_adr_i, wb_sel_i, wb_dat_i} = 40'h0000000000;
      void'($urandom(53884));
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check(32'(txd), 32'h00000001);
      check(32'(rts), 32'(exp_rts(0, int'(RTS_LVL_RST), 1'b0, 1'b1)));
      wb(ADDR_CTRL, 1'b0, 32'h00000000);
      check(q, 32'(CTRL_RST));
      wb(ADDR_DIV, 1'b0, 32'h00000000);
      check(q, 32'(DIV_RST));
      wb(4'h6, 1'b0, 32'h00000000);
      check(32'(e), 32'h00000001);
      wb(ADDR_STAT, 1'b0, 32'h00000000);
      check(q, (32'h1 << STAT_RX_EMPTY) | (32'h1 << STAT_CTS));
      wb(ADDR_DIV, 1'b1, 32'(SIM_DIV));
      $display("test reset done");
      for (int p = 0; p < 2; p++) begin
         pol <= p[0];
         for (int lvl = 2; lvl <= 4; lvl += 2) begin
            wb(ADDR_CTRL, 1'b1, {19'h0, 5'(lvl), 4'h0, p[0], 1'b1, p[0], 1'b1});
            repeat (3) @(posedge clk);
            check(32'(rts), 32'(exp_rts(0, lvl, p[0], 1'b1)));
            for (int i = 0; i < lvl; i++) begin
               exp_q.push_back(8'($urandom));
               host.send_char(exp_q[i]);
            end
            repeat (4) @(posedge clk);
            check(32'(rts), 32'(exp_rts(lvl, lvl, p[0], 1'b1)));
            for (int i = 0; i < lvl; i++) begin
               wb(ADDR_DATA, 1'b0, 32'h00000000);
               check({24'h000000, q[7:0]}, 32'(exp_q[i]));
               repeat (3) @(posedge clk);
               check(32'(rts), 32'(exp_rts(lvl - i - 1, lvl, p[0], 1'b1)));
            end
            wb(ADDR_DATA, 1'b0, 32'h00000000);
            check(q, 32'h00000000);
            exp_q.delete();
         end
         tx_burst(3);
         tx_check();
         ready <= 1'b0;
         tx_burst(2);
         repeat (300) @(posedge clk);
         check(32'(host.got_q.size()), 32'h00000000);
         ready <= 1'b1;
         tx_check();
         $display("test polarity %0d done", p);
      end
      pol <= 1'b0;
      wb(ADDR_CTRL, 1'b1, 32'h00000400);
      ready <= 1'b0;
      repeat (3) @(posedge clk);
      check(32'(rts), 32'(exp_rts(0, int'(RTS_LVL_RST), 1'b0, 1'b0)));
      tx_burst(2);
      tx_check();
      $display("test disable done");
      give_verdict();
   end
endmodule
